// >>> cos_pkg.sv
// package of constants, types and register map for the current output scaler
package cos_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int TENTH_S_NS    = 100000000;                   // 0.1 s step of the hold timer
    localparam int TENTH_CYCLES  = TENTH_S_NS / CLK_PERIOD_NS;  // least count is one cycle
    localparam int TENTHS_PER_S  = 10;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_SCALE_LO = 8'h04;
    localparam logic [7:0] OFS_SCALE_HI = 8'h08;
    localparam logic [7:0] OFS_EXT      = 8'h0c;
    localparam logic [7:0] OFS_SWING    = 8'h10;
    localparam logic [7:0] OFS_HOLD_T   = 8'h14;
    localparam logic [7:0] OFS_OFFSET   = 8'h18;
    localparam logic [7:0] OFS_BUS_SP   = 8'h1c;
    localparam logic [7:0] OFS_BUS_TO   = 8'h20;
    localparam logic [7:0] OFS_STATUS   = 8'h24;
    localparam logic [7:0] OFS_SETPOINT = 8'h28;
    localparam logic [7:0] OFS_CAPTURE  = 8'h2c;

    // control register field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_FAULT_LSB = 2;
    localparam int CTRL_CUR_SRC   = 4;
    localparam int CTRL_DISP_SRC  = 5;
    localparam int CTRL_RELAY_LSB = 6;
    localparam int CTRL_KIND      = 10;
    localparam int EXT_HI_LSB     = 16;

    // currents in 1/256 mA
    localparam logic signed [31:0] I_BASE_4MA  = 32'sh0000_0400;
    localparam logic signed [31:0] I_NOM_20MA  = 32'sh0000_1400;
    localparam logic signed [31:0] I_ABS_MAX   = 32'sh0000_1800;  // 24 mA
    localparam logic signed [31:0] SPAN_16MA   = 32'sh0000_1000;
    localparam logic signed [31:0] SPAN_20MA   = 32'sh0000_1400;
    localparam logic signed [31:0] PERMILLE    = 32'sh0000_03e8;
    localparam logic [15:0]        I_FAULT_HI  = 16'h161a;        // 22.1 mA
    localparam logic [15:0]        I_FAULT_LO  = 16'h0366;        // 3.4 mA
    localparam logic [15:0]        I_ZERO      = 16'h0000;

    // setting limits
    localparam logic [15:0] LO_EXT_MAX = 16'h03e7;  // 99.9 %
    localparam logic [15:0] HI_EXT_MAX = 16'h00c7;  // 19.9 %
    localparam logic [15:0] HOLD_T_MAX = 16'h00c7;  // 19.9 s
    localparam logic [15:0] BUS_TO_MAX = 16'h0063;  // 99 s
    localparam logic [15:0] OFFSET_MAX = 16'h0063;  // 99 degrees

    // values after reset
    localparam logic [15:0] RST_SCALE_LO = 16'h0000;
    localparam logic [15:0] RST_SCALE_HI = 16'h03e8;
    localparam logic [15:0] RST_SWING    = 16'h000a;
    localparam logic [15:0] RST_ZERO16   = 16'h0000;

    typedef enum logic [1:0] {COS_OFF, COS_0_20, COS_4_20, COS_BUS} cos_mode_e;
    typedef enum logic [1:0] {COS_NO_CHANGE, COS_F_22MA1, COS_F_3MA4, COS_F_0MA} cos_fault_e;

    typedef struct packed {
        cos_mode_e         mode;
        cos_fault_e        fault;
        logic              cur_src;       // current_out_source: 1 = captured
        logic              disp_src;      // display_source: 1 = captured
        logic [3:0]        relay_src;     // relay_source_1..4
        logic              detect_kind;   // 0 = peak, 1 = drop
        logic signed [15:0] scale_lo;     // scale_low_input
        logic signed [15:0] scale_hi;     // scale_high_input
        logic [9:0]        lo_ext;        // lower_extension_pct in 0.1 %
        logic [7:0]        hi_ext;        // upper_extension_pct in 0.1 %
        logic [15:0]       swing;         // minimum_swing
        logic [7:0]        hold_t;        // peak_show_duration in 0.1 s
        logic signed [7:0] offset;        // scale_offset in degrees
        logic [15:0]       bus_sp;        // bus setpoint, 1/256 mA
        logic [6:0]        bus_to;        // bus timeout in s
    } cos_cfg_s;

    typedef struct packed {
        logic [15:0] display;
        logic [3:0][15:0] relay;
    } cos_view_s;

endpackage

// >>> cos_scaler.sv
// current output scaler with peak capture, source selection and register port
`timescale 1ns/10ps
// Contract
// - modes: disabled, 0-20 mA, 4-20 mA, bus-written setpoint.
// - scale_low_input maps to 0 mA or 4 mA by mode.
// - scale_high_input maps to exactly 20 mA.
// - 4-20 mode: (W-low)/(high-low)*16 mA + 4 mA.
// - 0-20 mode: (W-low)/(high-low)*20 mA.
// - low above high gives a falling characteristic, same formulas.
// - out-of-range setpoint clamps to nearer limit, never beyond 0-24 mA.
// - lower limit is 4 mA less lower_extension_pct of 4 mA; the code uses 0 mA as the lower limit in 0-20 mode.
// - upper limit is 20 mA plus upper_extension_pct of 20 mA.
// - critical situation applies fault level: hold, 22.1, 3.4 or 0 mA; in bus mode critical_in is ignored and only the bus timeout applies it.
// - after the critical situation the computed value returns.
// - current_out_source picks live reading or captured value.
// - peak or drop captured only when swing reaches minimum_swing.
// - captured value kept at most peak_show_duration, 0.1 s steps.
// - zero duration: hold until escape if captured shown, else none.
// - display_source picks live reading or captured value.
// - each of four relays picks live reading or captured value.
// - signed scale_offset within 99 degrees added to measurement.
// - bus setpoint in 1/256 mA, high byte integer part.
// - no bus write longer than timeout applies fault level.
module cos_scaler #(
    parameter int TICK_CYCLES = cos_pkg::TENTH_CYCLES
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic [7:0]         addr_in,
    input  wire logic [31:0]        wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output logic [31:0]             rdata_out,
    input  wire logic signed [15:0] meas_in,
    input  wire logic               meas_valid_in,
    input  wire logic               critical_in,
    input  wire logic               esc_key_in,
    output logic [15:0]             setpoint_out,
    output logic                    out_en_out,
    output logic                    fault_out,
    output cos_pkg::cos_view_s      view_out
);

    typedef struct packed {
        cos_pkg::cos_cfg_s  cfg;
        logic               esc_meta;
        logic               esc_sync;
        logic               esc_prev;
        logic [23:0]        tick_cnt;
        logic [3:0]         tenth_cnt;
        logic [6:0]         sec_cnt;
        logic signed [15:0] live;
        logic signed [15:0] track;
        logic signed [15:0] peak;
        logic               peak_valid;
        logic [7:0]         hold_cnt;
        logic [15:0]        setpoint;
        logic               out_en;
        logic               fault;
        cos_pkg::cos_view_s view;
        logic [31:0]        rdata;
    } cos_state_s;

    cos_state_s state_r;
    cos_state_s state_nxt;

    // saturate an unsigned write value to a ceiling
    function automatic logic [15:0] sat_u(input logic [15:0] val, input logic [15:0] top);
        sat_u = (val > top) ? top : val;
    endfunction

    // difference of two signed words, one bit wider
    function automatic logic signed [16:0] sdiff(input logic signed [15:0] a, input logic signed [15:0] b);
        sdiff = 17'({a[15], a}) - 17'({b[15], b});
    endfunction

    // linear scaling of the source value, result in 1/256 mA
    function automatic logic signed [31:0] scale_val(input logic signed [15:0] w, input cos_pkg::cos_cfg_s c);
        logic signed [31:0] num;
        logic signed [31:0] den;
        logic signed [31:0] span;
        logic signed [31:0] base;
        span = (c.mode == cos_pkg::COS_4_20) ? cos_pkg::SPAN_16MA : cos_pkg::SPAN_20MA;
        base = (c.mode == cos_pkg::COS_4_20) ? cos_pkg::I_BASE_4MA : 32'sh0;
        num  = 32'(sdiff(w, c.scale_lo)) * span;
        den  = 32'(sdiff(c.scale_hi, c.scale_lo));                                     // sign carries reversal
        if (den == 32'sh0)
        begin
            scale_val = base;
        end
        else
        begin
            scale_val = num / den + base;
        end
    endfunction

    // clamp to the extended working range, never outside 0-24 mA
    function automatic logic [15:0] clamp_val(input logic signed [31:0] v, input cos_pkg::cos_cfg_s c);
        logic signed [31:0] lo;
        logic signed [31:0] hi;
        lo = cos_pkg::I_BASE_4MA - (cos_pkg::I_BASE_4MA * 32'($unsigned(c.lo_ext))) / cos_pkg::PERMILLE;
        hi = cos_pkg::I_NOM_20MA + (cos_pkg::I_NOM_20MA * 32'($unsigned(c.hi_ext))) / cos_pkg::PERMILLE;
        if (c.mode == cos_pkg::COS_0_20)
        begin
            lo = 32'sh0;
        end
        if (hi > cos_pkg::I_ABS_MAX)
        begin
            hi = cos_pkg::I_ABS_MAX;
        end
        if (v < lo)
        begin
            clamp_val = lo[15:0];
        end
        else if (v > hi)
        begin
            clamp_val = hi[15:0];
        end
        else
        begin
            clamp_val = v[15:0];
        end
    endfunction

    logic signed [15:0] held_val;
    logic signed [15:0] src_val;
    logic signed [15:0] meas_ofs;
    logic signed [16:0] meas_sum;
    logic               tenth_tick;
    logic               sec_tick;
    logic               esc_edge;
    logic               bus_wr;
    logic               crit;
    logic [15:0]        calc_sp;
    logic [15:0]        fault_sp;
    logic signed [15:0] ofs_w;

    // shared decodes and the value chosen for the setpoint
    always_comb
    begin
        held_val   = state_r.peak_valid ? state_r.peak : state_r.live;
        src_val    = state_r.cfg.cur_src ? held_val : state_r.live;
        meas_sum   = 17'({meas_in[15], meas_in}) + 17'({{8{state_r.cfg.offset[7]}}, state_r.cfg.offset});
        meas_ofs   = meas_sum[15:0];
        tenth_tick = (state_r.tick_cnt == 24'(TICK_CYCLES - 1));
        sec_tick   = tenth_tick && (state_r.tenth_cnt == 4'(cos_pkg::TENTHS_PER_S - 1));
        esc_edge   = state_r.esc_sync && !state_r.esc_prev;
        bus_wr     = wr_in && (addr_in == cos_pkg::OFS_BUS_SP);
        ofs_w      = 16'($signed(wdata_in[15:0]));
        if (ofs_w > $signed(cos_pkg::OFFSET_MAX))
        begin
            ofs_w = $signed(cos_pkg::OFFSET_MAX);
        end
        else if (ofs_w < -$signed(cos_pkg::OFFSET_MAX))
        begin
            ofs_w = -$signed(cos_pkg::OFFSET_MAX);
        end
        // bus mode setpoint also kept inside 0-24 mA
        if (state_r.cfg.mode == cos_pkg::COS_BUS)
        begin
            calc_sp = (state_r.cfg.bus_sp > cos_pkg::I_ABS_MAX[15:0]) ? cos_pkg::I_ABS_MAX[15:0]
                      : state_r.cfg.bus_sp;
            crit    = (state_r.cfg.bus_to != 7'h0) && (state_r.sec_cnt > state_r.cfg.bus_to);
        end
        else
        begin
            calc_sp = clamp_val(scale_val(src_val, state_r.cfg), state_r.cfg);
            crit    = critical_in;
        end
        case (state_r.cfg.fault)
            cos_pkg::COS_NO_CHANGE: fault_sp = state_r.setpoint;
            cos_pkg::COS_F_22MA1:   fault_sp = cos_pkg::I_FAULT_HI;
            cos_pkg::COS_F_3MA4:    fault_sp = cos_pkg::I_FAULT_LO;
            cos_pkg::COS_F_0MA:     fault_sp = cos_pkg::I_ZERO;
            default:                fault_sp = state_r.setpoint;
        endcase
    end

    // next-state logic for the whole block
    always_comb
    begin
        logic cap_now;                                                                  // a capture in this cycle
        cap_now   = 1'b0;
        state_nxt = state_r;

        // escape key synchroniser
        state_nxt.esc_meta = esc_key_in;
        state_nxt.esc_sync = state_r.esc_meta;
        state_nxt.esc_prev = state_r.esc_sync;

        // tenth-second and second time base
        state_nxt.tick_cnt = tenth_tick ? 24'h0 : state_r.tick_cnt + 24'h1;
        if (tenth_tick)
        begin
            state_nxt.tenth_cnt = sec_tick ? 4'h0 : state_r.tenth_cnt + 4'h1;
        end

        // seconds since the last bus setpoint write, saturating
        if (bus_wr)
        begin
            state_nxt.sec_cnt = 7'h0;
        end
        else if (sec_tick && (state_r.sec_cnt != 7'h7f))
        begin
            state_nxt.sec_cnt = state_r.sec_cnt + 7'h1;
        end

        // live reading with offset
        if (meas_valid_in)
        begin
            state_nxt.live = meas_ofs;
        end

        // peak or drop tracking on each new reading
        if (meas_valid_in)
        begin
            if (!state_r.cfg.detect_kind)
            begin
                if (meas_ofs > state_r.track)
                begin
                    state_nxt.track = meas_ofs;
                end
                else if (sdiff(state_r.track, meas_ofs) >= 17'({1'b0, state_r.cfg.swing}))
                begin
                    cap_now              = 1'b1;
                    state_nxt.peak       = state_r.track;
                    state_nxt.peak_valid = 1'b1;
                    state_nxt.hold_cnt   = state_r.cfg.hold_t;
                    state_nxt.track      = meas_ofs;
                end
            end
            else
            begin
                if (meas_ofs < state_r.track)
                begin
                    state_nxt.track = meas_ofs;
                end
                else if (sdiff(meas_ofs, state_r.track) >= 17'({1'b0, state_r.cfg.swing}))
                begin
                    cap_now              = 1'b1;
                    state_nxt.peak       = state_r.track;
                    state_nxt.peak_valid = 1'b1;
                    state_nxt.hold_cnt   = state_r.cfg.hold_t;
                    state_nxt.track      = meas_ofs;
                end
            end
        end

        // expiry of the captured value; a new capture wins over expiry
        if (state_r.peak_valid && !cap_now)
        begin
            if (state_r.cfg.hold_t == 8'h0)
            begin
                if (!state_r.cfg.disp_src || esc_edge)
                begin
                    state_nxt.peak_valid = 1'b0;
                end
            end
            else if (tenth_tick)
            begin
                if (state_r.hold_cnt <= 8'h1)
                begin
                    state_nxt.peak_valid = 1'b0;
                end
                else
                begin
                    state_nxt.hold_cnt = state_r.hold_cnt - 8'h1;
                end
            end
        end

        // setpoint and output enable
        state_nxt.out_en = (state_r.cfg.mode != cos_pkg::COS_OFF);
        state_nxt.fault  = crit && (state_r.cfg.mode != cos_pkg::COS_OFF);
        if (state_r.cfg.mode == cos_pkg::COS_OFF)
        begin
            state_nxt.setpoint = cos_pkg::I_ZERO;
        end
        else if (crit)
        begin
            state_nxt.setpoint = fault_sp;
        end
        else
        begin
            state_nxt.setpoint = calc_sp;
        end

        // display and relay sources
        state_nxt.view.display = state_r.cfg.disp_src ? held_val : state_r.live;
        for (int i = 0; i < 4; i++)
        begin
            state_nxt.view.relay[i] = state_r.cfg.relay_src[i] ? held_val : state_r.live;
        end

        // register writes
        if (wr_in)
        begin
            case (addr_in)
                cos_pkg::OFS_CTRL:
                begin
                    state_nxt.cfg.mode        = cos_pkg::cos_mode_e'(wdata_in[cos_pkg::CTRL_MODE_LSB +: 2]);
                    state_nxt.cfg.fault       = cos_pkg::cos_fault_e'(wdata_in[cos_pkg::CTRL_FAULT_LSB +: 2]);
                    state_nxt.cfg.cur_src     = wdata_in[cos_pkg::CTRL_CUR_SRC];
                    state_nxt.cfg.disp_src    = wdata_in[cos_pkg::CTRL_DISP_SRC];
                    state_nxt.cfg.relay_src   = wdata_in[cos_pkg::CTRL_RELAY_LSB +: 4];
                    state_nxt.cfg.detect_kind = wdata_in[cos_pkg::CTRL_KIND];
                end
                cos_pkg::OFS_SCALE_LO: state_nxt.cfg.scale_lo = $signed(wdata_in[15:0]);
                cos_pkg::OFS_SCALE_HI: state_nxt.cfg.scale_hi = $signed(wdata_in[15:0]);
                cos_pkg::OFS_EXT:
                begin
                    state_nxt.cfg.lo_ext = 10'(sat_u(wdata_in[15:0], cos_pkg::LO_EXT_MAX));
                    state_nxt.cfg.hi_ext = 8'(sat_u(wdata_in[cos_pkg::EXT_HI_LSB +: 16],
                                                    cos_pkg::HI_EXT_MAX));
                end
                cos_pkg::OFS_SWING:    state_nxt.cfg.swing  = wdata_in[15:0];
                cos_pkg::OFS_HOLD_T:   state_nxt.cfg.hold_t = 8'(sat_u(wdata_in[15:0], cos_pkg::HOLD_T_MAX));
                cos_pkg::OFS_OFFSET:   state_nxt.cfg.offset = ofs_w[7:0];
                cos_pkg::OFS_BUS_SP:   state_nxt.cfg.bus_sp = wdata_in[15:0];
                cos_pkg::OFS_BUS_TO:   state_nxt.cfg.bus_to = 7'(sat_u(wdata_in[15:0], cos_pkg::BUS_TO_MAX));
                default:               state_nxt.cfg = state_r.cfg;
            endcase
        end

        // register reads, data valid only in the following cycle
        state_nxt.rdata = 32'h0;
        if (rd_in)
        begin
            case (addr_in)
                cos_pkg::OFS_CTRL:     state_nxt.rdata = {21'h0, state_r.cfg.detect_kind, state_r.cfg.relay_src,
                                                          state_r.cfg.disp_src, state_r.cfg.cur_src,
                                                          state_r.cfg.fault, state_r.cfg.mode};
                cos_pkg::OFS_SCALE_LO: state_nxt.rdata = {16'h0, state_r.cfg.scale_lo};
                cos_pkg::OFS_SCALE_HI: state_nxt.rdata = {16'h0, state_r.cfg.scale_hi};
                cos_pkg::OFS_EXT:      state_nxt.rdata = {8'h0, state_r.cfg.hi_ext, 6'h0, state_r.cfg.lo_ext};
                cos_pkg::OFS_SWING:    state_nxt.rdata = {16'h0, state_r.cfg.swing};
                cos_pkg::OFS_HOLD_T:   state_nxt.rdata = {24'h0, state_r.cfg.hold_t};
                cos_pkg::OFS_OFFSET:   state_nxt.rdata = {24'h0, state_r.cfg.offset};
                cos_pkg::OFS_BUS_SP:   state_nxt.rdata = {16'h0, state_r.cfg.bus_sp};
                cos_pkg::OFS_BUS_TO:   state_nxt.rdata = {25'h0, state_r.cfg.bus_to};
                cos_pkg::OFS_STATUS:   state_nxt.rdata = {21'h0, state_r.sec_cnt, state_r.hold_cnt == 8'h0,
                                                          state_r.out_en, state_r.fault, state_r.peak_valid};
                cos_pkg::OFS_SETPOINT: state_nxt.rdata = {16'h0, state_r.setpoint};
                cos_pkg::OFS_CAPTURE:  state_nxt.rdata = {16'h0, state_r.peak};
                default:               state_nxt.rdata = 32'h0;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r                  <= '0;
            state_r.cfg.scale_lo     <= cos_pkg::RST_SCALE_LO;
            state_r.cfg.scale_hi     <= cos_pkg::RST_SCALE_HI;
            state_r.cfg.swing        <= cos_pkg::RST_SWING;
            state_r.cfg.mode         <= cos_pkg::COS_OFF;
            state_r.cfg.fault        <= cos_pkg::COS_NO_CHANGE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state register
    assign rdata_out    = state_r.rdata;
    assign setpoint_out = state_r.setpoint;
    assign out_en_out   = state_r.out_en;
    assign fault_out    = state_r.fault;
    assign view_out     = state_r.view;

endmodule

// >>> cos_loop_model.sv
// behavioural model of the analogue loop driver stage
`timescale 1ns/10ps
module cos_loop_model (
    input  wire logic        clk_in,
    input  wire logic        en_in,
    input  wire logic [15:0] setpoint_in,
    output int               loop_ua_out
);
    // setpoint in 1/256 mA turned into microamps, loop open when disabled
    always @(posedge clk_in)
    begin
        loop_ua_out <= en_in ? int'(setpoint_in) * 1000 / 256 : 0;
    end
endmodule

// >>> cos_scaler_properties.sv
// port-level properties of the current output scaler
`timescale 1ns/10ps
module cos_scaler_chk #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        meas_valid_in,
    input wire logic        critical_in,
    input wire logic [15:0] setpoint_out,
    input wire logic        out_en_out,
    input wire logic        fault_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // read data only in the cycle after a read strobe
    chk_rd_idle: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not idle");
    chk_sp_ceiling: assert property (setpoint_out <= 16'h1800)
        else $error("setpoint above 24 mA");
    chk_off_zero: assert property (!out_en_out |-> setpoint_out == 16'h0)
        else $error("disabled output not zero");
    chk_crit_fault: assert property (critical_in && out_en_out && !wr_in |=> fault_out)
        else $error("critical without fault");
    chk_rd_setpt: assert property (rd_in && addr_in == cos_pkg::OFS_SETPOINT |=>
        rdata_out == {16'h0, $past(setpoint_out)}) else $error("setpoint read wrong");
    chk_rd_unmap: assert property (rd_in && addr_in == 8'h30 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_rd_status: assert property (rd_in && addr_in == cos_pkg::OFS_STATUS |=>
        rdata_out[2:1] == $past({out_en_out, fault_out})) else $error("status read wrong");
    chk_ctrl_back: assert property (wr_in && addr_in == 8'h00 ##1 rd_in && addr_in == 8'h00
        |=> rdata_out[10:0] == $past(wdata_in[10:0], 2)) else $error("control readback wrong");
    cover property (critical_in && out_en_out);
    cover property (meas_valid_in && out_en_out);
    cover property (rd_in && addr_in == cos_pkg::OFS_STATUS);
endmodule

// >>> tb_top.sv
// self-checking bench of the current output scaler
`timescale 1ns/10ps
module tb_top;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, mv = 0, crit = 0, esc = 0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic signed [15:0] meas = 16'sh0;
    logic [15:0] sp;
    logic oen, flt;
    cos_pkg::cos_view_s view;
    int err_count = 0, checks_done = 0, seed = 32'haeb3, ua, w, lo, hi;
    int fl[4] = '{32'hc00, 32'h161a, 32'h366, 32'h0};
    int cw[5] = '{100, 200, 150, 0, 300};
    always #4 clk = ~clk;
    cos_scaler #(.TICK_CYCLES(10)) dut_u (.clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .meas_in(meas),
        .meas_valid_in(mv), .critical_in(crit), .esc_key_in(esc), .setpoint_out(sp),
        .out_en_out(oen), .fault_out(flt), .view_out(view));
    cos_loop_model loop_u (.clk_in(clk), .en_in(oen), .setpoint_in(sp), .loop_ua_out(ua));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wreg(logic [7:0] a, logic [31:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 0;
    endtask
    task automatic rreg(logic [7:0] a, logic [31:0] e, string nm, logic [31:0] m = 32'hffff_ffff);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 0;
        @(negedge clk) chk(nm, rdata & m, e);
    endtask
    task automatic feed(int v);
        @(posedge clk) {mv, meas} <= {1'b1, 16'(v)};
        @(posedge clk) mv <= 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    // setpoint in 1/256 mA from the scaling formulas and clamp limits
    function automatic int exp_sp(int md, int l, int h, int v);
        int b = md == 2 ? 1024 : 0;
        int r = h == l ? b : (v - l) * (md == 2 ? 4096 : 5120) / (h - l) + b;
        int mn = md == 2 ? 1024 - 1024 * 250 / 1000 : 0;
        int mx = 5120 + 5120 * 50 / 1000;
        return r < mn ? mn : (r > mx ? mx : r);
    endfunction
    initial
    begin
        #200000 err_count++;
        end_sim();
    end
    // reset values, mapped sweep, faults, bus mode, capture, disable
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rreg(8'h00, 32'h0, "ctrl");
        rreg(8'h08, 32'h3e8, "scale_hi");
        rreg(8'h10, 32'ha, "swing");
        rreg(8'h30, 32'h0, "unmapped");
        wreg(8'h0c, 32'h0032_00fa);
        for (int md = 1; md < 3; md++)
            for (int rv_i = 0; rv_i < 2; rv_i++)
            begin
                lo = rv_i ? 200 : 100;
                hi = rv_i ? 100 : 200;
                wreg(8'h04, lo);
                wreg(8'h08, hi);
                wreg(8'h00, md);
                for (int i = 0; i < 10; i++)
                begin
                    w = i < 5 ? cw[i] : 100 + $unsigned($random(seed)) % 101;
                    feed(w);
                    chk("setpoint", sp, exp_sp(md, lo, hi, w));
                end
            end
        wreg(8'h04, 100);
        wreg(8'h08, 200);
        wreg(8'h18, 5);
        feed(145);
        chk("offset", sp, 32'hc00);
        chk("loop", ua, 12000);
        for (int f = 0; f < 4; f++)
        begin
            wreg(8'h00, 2 | f << 2);
            @(posedge clk) crit <= 1;
            repeat (3) @(negedge clk);
            chk("fault level", sp, fl[f]);
            chk("fault flag", flt, 1);
            @(posedge clk) crit <= 0;
            repeat (3) @(negedge clk);
            chk("after fault", sp, 32'hc00);
            chk("fault clear", flt, 0);
        end
        wreg(8'h20, 1);
        wreg(8'h00, 32'h7);
        wreg(8'h1c, 32'ha80);
        repeat (3) @(negedge clk);
        chk("bus setpoint", sp, 32'ha80);
        wreg(8'h1c, 32'h2000);
        repeat (3) @(negedge clk);
        chk("bus cap", sp, 32'h1800);
        repeat (400) @(negedge clk);
        chk("bus timeout", sp, 32'h161a);
        rreg(8'h24, 32'h6, "status", 32'h6);
        wreg(8'h18, 0);
        wreg(8'h00, 2);
        feed(100);
        wreg(8'h00, 32'h72);
        feed(150);
        feed(180);
        feed(160);
        chk("captured", sp, exp_sp(2, 100, 200, 180));
        chk("display", view.display, 180);
        chk("relay held", view.relay[0], 180);
        chk("relay live", view.relay[1], 160);
        @(posedge clk) esc <= 1;
        repeat (6) @(posedge clk);
        esc <= 0;
        feed(170);
        chk("after escape", sp, exp_sp(2, 100, 200, 170));
        wreg(8'h14, 2);
        feed(200);
        feed(150);
        chk("held", sp, exp_sp(2, 100, 200, 200));
        repeat (25) @(negedge clk);
        chk("hold expiry", sp, exp_sp(2, 100, 200, 150));
        @(posedge clk) {wr, addr, wdata} <= {1'b1, 8'h00, 32'h7f0};
        @(posedge clk) {wr, rd} <= 2'b01;
        @(posedge clk) rd <= 0;
        @(negedge clk) chk("ctrl readback", rdata, 32'h7f0);
        repeat (3) @(negedge clk);
        chk("disabled", {oen, sp}, 0);
        end_sim();
    end
endmodule
bind cos_scaler cos_scaler_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .meas_valid_in(meas_valid_in), .critical_in(critical_in), .setpoint_out(setpoint_out),
    .out_en_out(out_en_out), .fault_out(fault_out));
